// ==== hw/pur_regs.svh ====
/*
 * Register indices, field positions, reset values and timing constants of
 * the power-up reset sequencer.
 * Assumes a 250 MHz ref_clk and 32-bit AXI4-Lite with 12-bit byte addresses.
 */
`ifndef PUR_REGS_SVH
`define PUR_REGS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PUR_ADDR_W 12
`define PUR_IDX_POWER_CONTROL 10'h08E
`define PUR_IDX_IRQ_STATUS 10'h090
`define PUR_IDX_IRQ_MASK 10'h091
`define PUR_IDX_FLAGS 10'h092
`define PUR_IDX_CONFIG 10'h093

// ****************************************************************
// Field positions
// ****************************************************************
`define PUR_BIT_POR_FLAG 1
`define PUR_BIT_TIMEOUT 0
`define PUR_BIT_POWER_DOWN 1
`define PUR_BIT_CORE_RESET 2
`define PUR_BIT_DELAY_DISABLE 0
`define PUR_OSC_MODE_LSB 1
`define PUR_OSC_MODE_MSB 2
`define PUR_EV_POWER_ON 0
`define PUR_EV_WDT_RESET 1
`define PUR_EV_WDT_WAKE 2
`define PUR_EV_MASTER_CLEAR_PIN_RESET 3
`define PUR_EV_N 4

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define PUR_CONFIG_RST 8'h02
`define PUR_MASK_RST 4'h0
`define PUR_RESP_OKAY 2'h0
`define PUR_RESP_SLVERR 2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define PUR_CLK_MHZ 250
`define PUR_POWER_UP_DELAY_TIMER_TIME_US 72000
`define PUR_OST_CYCLES 1024
`define PUR_CNT_W 32

`endif

// ==== hw/pur_pkg.sv ====
/*
 * Types shared by the sequencer and its delay counter.
 * Assumes pur_regs.svh is on the include path.
 */
`include "pur_regs.svh"

package pur_pkg;

    typedef enum logic [1:0] {
        OSC_LOW_POWER_CRYSTAL,
        OSC_CRYSTAL,
        OSC_HIGH_SPEED_CRYSTAL,
        OSC_RESISTOR_CAPACITOR
    } pur_osc_e;

    typedef enum logic [2:0] {
        ST_SUPPLY_OFF,
        ST_POR_PULSE,
        ST_POWER_UP_DELAY,
        ST_OSC_STARTUP,
        ST_RUN,
        ST_SLEEP,
        ST_WAKE_STARTUP,
        ST_WDT_RESET
    } pur_state_e;

    typedef enum logic [2:0] {
        REG_NONE,
        REG_POWER_CONTROL,
        REG_IRQ_STATUS,
        REG_IRQ_MASK,
        REG_FLAGS,
        REG_CONFIG
    } pur_reg_e;

    typedef struct packed {
        logic busy;
        logic done;
        logic [`PUR_CNT_W-1:0] count;
    } pur_cnt_s;

    typedef struct packed {
        pur_state_e state;
        logic supply_prev;
        logic osc_prev;
        logic master_clear_pin_prev;
        logic core_reset;
        logic core_wake;
        logic por_flag;
        logic timeout_flag;
        logic power_down_flag;
        logic power_up_delay_timer_start;
        logic ost_start;
        logic [`PUR_EV_N-1:0] irq_status;
        logic [`PUR_EV_N-1:0] irq_mask;
        logic irq;
        logic [7:0] cfg;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic [`PUR_ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } pur_top_s;

endpackage : pur_pkg

// ==== hw/pur_cnt_if.sv ====
/*
 * Link between the sequencer and one delay counter.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/1ns
`include "pur_regs.svh"

interface pur_cnt_if;
    logic start;
    logic tick;
    logic [`PUR_CNT_W-1:0] limit;
    logic busy;
    logic done;

    modport ctl (output start, output tick, output limit, input busy, input done);
    modport cnt (input start, input tick, input limit, output busy, output done);
endinterface : pur_cnt_if

// ==== hw/pur_delay_cnt.sv ====
/*
 * Delay counter: counts limit ticks after a start pulse, then pulses done.
 * Assumes limit is at least one and stable while busy.
 */
`timescale 1ns/1ns
`include "pur_regs.svh"

module pur_delay_cnt (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control link
    pur_cnt_if.cnt link
);

    pur_pkg::pur_cnt_s q;
    pur_pkg::pur_cnt_s next_q;

    assign link.busy = q.busy;
    assign link.done = q.done;

    always_comb begin
        next_q = q;
        next_q.done = 1'b0;
        if (link.start) begin
            next_q.busy = 1'b1;
            next_q.count = '0;
        end else if (q.busy && link.tick) begin
            if (q.count == link.limit - `PUR_CNT_W'(1)) begin
                next_q.busy = 1'b0;
                next_q.done = 1'b1;
            end else begin
                next_q.count = q.count + `PUR_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule : pur_delay_cnt

// ==== hw/pur_seq.sv ====
/*
 * Power-up reset sequencer with power control register, reset-cause flags
 * and an AXI4-Lite register slave.
 * Assumes all pins synchronous to ref_clk; supply_good comes from an analog
 * supply detector, main_osc_input is the oscillator input sampled at ref_clk,
 * and ref_clk stands in for the internal RC oscillator.
 */
//
// Overview of operation
// - A rising supply makes an internal power-on pulse that starts the timeouts.
// - A falling supply causes no internal reset.
// - Power-up delay of nominally 72 ms, only after power-on, never other resets.
// - The power-up delay is timed by the internal RC clock, not the oscillator.
// - The chip stays in reset while the power-up delay runs.
// - Configuration bit set skips the power-up delay; cleared applies it.
// - After the power-up delay, 1024 oscillator input cycles pass before release.
// - Oscillator count only in crystal modes, only after power-on or wake.
// - Order: power-on pulse, then power-up delay, then oscillator count.
// - RC mode with power-up delay disabled has no timeout at all.
// - Power-on delays run despite master clear; late pin release starts at once.
// - Power-on flag bit 1 is forced to 0 by power-on only.
// - Power control bits 7..2 and bit 0 read as zero.
// - Power-on sets timeout and power-down status flags to 1.
// - Flags with power-on flag 1 tell watchdog reset, wake or sleep clear.
// - Watchdog timeout clears the timeout status flag.
// - Watchdog timeout resets when running, wakes the device when asleep.
//
`timescale 1ns/1ns
`include "pur_regs.svh"

module pur_seq #(
    parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = `PUR_POWER_UP_DELAY_TIMER_TIME_US * `PUR_CLK_MHZ,
    parameter int unsigned OST_CYCLES = `PUR_OST_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Supply, pins and oscillator
    input wire logic supply_good,
    input wire logic master_clear_pin_n,
    input wire logic main_osc_input,
    // Core and watchdog events
    input wire logic watchdog_timeout,
    input wire logic core_sleep_cmd,
    input wire logic core_clear_watchdog,
    // Core control
    output logic core_reset,
    output logic core_wake,
    output logic timeout_status_flag,
    output logic power_down_status_flag,
    output logic irq,
    // AXI4-Lite write address
    input wire logic [`PUR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data and response
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [`PUR_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (POWER_UP_DELAY_TIMER_CYCLES < 1 || OST_CYCLES < 1) begin : g_bad_cycles
        $error("pur_seq: delay counts must be at least one cycle");
    end

    // ****************************************************************
    // Register decode
    // ****************************************************************
    function automatic pur_pkg::pur_reg_e reg_sel(input logic [`PUR_ADDR_W-1:0] a);
        pur_pkg::pur_reg_e r;
        unique case (a)
            {`PUR_IDX_POWER_CONTROL, 2'b00}: r = pur_pkg::REG_POWER_CONTROL;
            {`PUR_IDX_IRQ_STATUS, 2'b00}: r = pur_pkg::REG_IRQ_STATUS;
            {`PUR_IDX_IRQ_MASK, 2'b00}: r = pur_pkg::REG_IRQ_MASK;
            {`PUR_IDX_FLAGS, 2'b00}: r = pur_pkg::REG_FLAGS;
            {`PUR_IDX_CONFIG, 2'b00}: r = pur_pkg::REG_CONFIG;
            default: r = pur_pkg::REG_NONE;
        endcase
        return r;
    endfunction : reg_sel

    function automatic logic is_crystal(input logic [7:0] cfg);
        pur_pkg::pur_osc_e m;
        m = pur_pkg::pur_osc_e'(cfg[`PUR_OSC_MODE_MSB:`PUR_OSC_MODE_LSB]);
        return m != pur_pkg::OSC_RESISTOR_CAPACITOR;
    endfunction : is_crystal

    // ****************************************************************
    // Delay counters
    // ****************************************************************
    pur_pkg::pur_top_s q;
    pur_pkg::pur_top_s next_q;
    pur_cnt_if power_up_delay_timer_link ();
    pur_cnt_if ost_link ();
    assign power_up_delay_timer_link.start = q.power_up_delay_timer_start;
    assign power_up_delay_timer_link.tick = 1'b1;
    assign power_up_delay_timer_link.limit = `PUR_CNT_W'(POWER_UP_DELAY_TIMER_CYCLES);
    assign ost_link.start = q.ost_start;
    assign ost_link.tick = main_osc_input & ~q.osc_prev;
    assign ost_link.limit = `PUR_CNT_W'(OST_CYCLES);
    pur_delay_cnt u_power_up_delay_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .link(power_up_delay_timer_link)
    );
    pur_delay_cnt u_osc_startup_counter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .link(ost_link)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic supply_rise;
    logic master_clear_pin_fall;
    logic wr_go;
    logic [`PUR_EV_N-1:0] ev;
    logic [`PUR_EV_N-1:0] ev_clr;
    pur_pkg::pur_reg_e wsel;
    pur_pkg::pur_reg_e rsel;
    assign supply_rise = supply_good & ~q.supply_prev;
    assign master_clear_pin_fall = q.master_clear_pin_prev & ~master_clear_pin_n;
    assign wr_go = ~q.awready & ~q.wready & ~q.bvalid;
    assign wsel = reg_sel(q.waddr);
    assign rsel = reg_sel(s_axi_araddr);
    always_comb begin
        next_q = q;
        ev = '0;
        ev_clr = '0;
        next_q.supply_prev = supply_good;
        next_q.osc_prev = main_osc_input;
        next_q.master_clear_pin_prev = master_clear_pin_n;
        next_q.power_up_delay_timer_start = 1'b0;
        next_q.ost_start = 1'b0;
        next_q.core_wake = 1'b0;

        // Write channel: address and data are taken in either order
        if (s_axi_awvalid && q.awready) begin
            next_q.awready = 1'b0;
            next_q.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            next_q.wready = 1'b0;
            next_q.wdata = s_axi_wdata;
            next_q.wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            next_q.bvalid = 1'b1;
            next_q.bresp = (wsel == pur_pkg::REG_NONE) ? `PUR_RESP_SLVERR : `PUR_RESP_OKAY;
        end
        if (wr_go && q.wstrb[0]) begin
            unique case (wsel)
                pur_pkg::REG_POWER_CONTROL: next_q.por_flag = q.wdata[`PUR_BIT_POR_FLAG];
                pur_pkg::REG_IRQ_STATUS: ev_clr = q.wdata[`PUR_EV_N-1:0];
                pur_pkg::REG_IRQ_MASK: next_q.irq_mask = q.wdata[`PUR_EV_N-1:0];
                pur_pkg::REG_CONFIG: next_q.cfg = q.wdata[7:0];
                pur_pkg::REG_FLAGS, pur_pkg::REG_NONE: begin
                end
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            next_q.bvalid = 1'b0;
            next_q.awready = 1'b1;
            next_q.wready = 1'b1;
        end

        // Read channel answers one cycle after the address is taken
        if (s_axi_arvalid && q.arready) begin
            next_q.arready = 1'b0;
            next_q.rvalid = 1'b1;
            next_q.rresp = `PUR_RESP_OKAY;
            next_q.rdata = '0;
            unique case (rsel)
                pur_pkg::REG_POWER_CONTROL: begin
                    next_q.rdata[`PUR_BIT_POR_FLAG] = q.por_flag;
                end
                pur_pkg::REG_IRQ_STATUS: next_q.rdata[`PUR_EV_N-1:0] = q.irq_status;
                pur_pkg::REG_IRQ_MASK: next_q.rdata[`PUR_EV_N-1:0] = q.irq_mask;
                pur_pkg::REG_FLAGS: begin
                    next_q.rdata[`PUR_BIT_TIMEOUT] = q.timeout_flag;
                    next_q.rdata[`PUR_BIT_POWER_DOWN] = q.power_down_flag;
                    next_q.rdata[`PUR_BIT_CORE_RESET] = q.core_reset;
                end
                pur_pkg::REG_CONFIG: next_q.rdata[7:0] = q.cfg;
                pur_pkg::REG_NONE: next_q.rresp = `PUR_RESP_SLVERR;
            endcase
        end
        if (q.rvalid && s_axi_rready) begin
            next_q.rvalid = 1'b0;
            next_q.arready = 1'b1;
        end

        // Sequencer
        unique case (q.state)
            pur_pkg::ST_SUPPLY_OFF: next_q.state = pur_pkg::ST_SUPPLY_OFF;
            pur_pkg::ST_POR_PULSE: begin
                if (!q.cfg[`PUR_BIT_DELAY_DISABLE]) begin
                    next_q.state = pur_pkg::ST_POWER_UP_DELAY;
                    next_q.power_up_delay_timer_start = 1'b1;
                end else if (is_crystal(q.cfg)) begin
                    next_q.state = pur_pkg::ST_OSC_STARTUP;
                    next_q.ost_start = 1'b1;
                end else begin
                    next_q.state = pur_pkg::ST_RUN;
                end
            end
            pur_pkg::ST_POWER_UP_DELAY: begin
                if (power_up_delay_timer_link.done) begin
                    if (is_crystal(q.cfg)) begin
                        next_q.state = pur_pkg::ST_OSC_STARTUP;
                        next_q.ost_start = 1'b1;
                    end else begin
                        next_q.state = pur_pkg::ST_RUN;
                    end
                end
            end
            pur_pkg::ST_OSC_STARTUP: begin
                if (ost_link.done) begin
                    next_q.state = pur_pkg::ST_RUN;
                end
            end
            pur_pkg::ST_RUN: begin
                if (master_clear_pin_fall) begin
                    ev[`PUR_EV_MASTER_CLEAR_PIN_RESET] = 1'b1;
                end
                if (master_clear_pin_n && watchdog_timeout) begin
                    next_q.state = pur_pkg::ST_WDT_RESET;
                    next_q.timeout_flag = 1'b0;
                    ev[`PUR_EV_WDT_RESET] = 1'b1;
                end else if (master_clear_pin_n && core_sleep_cmd && !q.core_reset) begin
                    next_q.state = pur_pkg::ST_SLEEP;
                    next_q.timeout_flag = 1'b1;
                    next_q.power_down_flag = 1'b0;
                end else if (master_clear_pin_n && core_clear_watchdog && !q.core_reset) begin
                    next_q.timeout_flag = 1'b1;
                    next_q.power_down_flag = 1'b1;
                end
            end
            pur_pkg::ST_SLEEP: begin
                if (!master_clear_pin_n) begin
                    // Pin reset during sleep keeps both flags as they stand
                    next_q.state = pur_pkg::ST_RUN;
                    ev[`PUR_EV_MASTER_CLEAR_PIN_RESET] = 1'b1;
                end else if (watchdog_timeout) begin
                    next_q.timeout_flag = 1'b0;
                    ev[`PUR_EV_WDT_WAKE] = 1'b1;
                    if (is_crystal(q.cfg)) begin
                        next_q.state = pur_pkg::ST_WAKE_STARTUP;
                        next_q.ost_start = 1'b1;
                    end else begin
                        next_q.state = pur_pkg::ST_RUN;
                        next_q.core_wake = 1'b1;
                    end
                end
            end
            pur_pkg::ST_WAKE_STARTUP: begin
                if (!master_clear_pin_n) begin
                    next_q.state = pur_pkg::ST_RUN;
                    ev[`PUR_EV_MASTER_CLEAR_PIN_RESET] = 1'b1;
                end else if (ost_link.done) begin
                    next_q.state = pur_pkg::ST_RUN;
                    next_q.core_wake = 1'b1;
                end
            end
            pur_pkg::ST_WDT_RESET: begin
                // Watchdog reset gets no power-up delay and no start-up count
                // power-up delay after power-up only, start-up count after power-up or wake
                next_q.state = pur_pkg::ST_RUN;
            end
        endcase

        // watchdog clears flag, also in wake count or with the pin just low
        if (watchdog_timeout && !q.core_reset) begin
            next_q.timeout_flag = 1'b0;
        end

        if (supply_rise) begin
            next_q.state = pur_pkg::ST_POR_PULSE;
            next_q.por_flag = 1'b0;
            next_q.timeout_flag = 1'b1;
            next_q.power_down_flag = 1'b1;
            next_q.core_wake = 1'b0;
            ev[`PUR_EV_POWER_ON] = 1'b1;
        end

        next_q.core_reset = !master_clear_pin_n || next_q.state inside {pur_pkg::ST_SUPPLY_OFF,
            pur_pkg::ST_POR_PULSE, pur_pkg::ST_POWER_UP_DELAY, pur_pkg::ST_OSC_STARTUP,
            pur_pkg::ST_WDT_RESET};

        // Set wins over a same-cycle write-one clear
        next_q.irq_status = (q.irq_status & ~ev_clr) | ev;
        next_q.irq = |(next_q.irq_status & next_q.irq_mask);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.state <= pur_pkg::ST_SUPPLY_OFF;
            q.master_clear_pin_prev <= 1'b1;
            q.core_reset <= 1'b1;
            q.timeout_flag <= 1'b1;
            q.power_down_flag <= 1'b1;
            q.irq_mask <= `PUR_MASK_RST;
            q.cfg <= `PUR_CONFIG_RST;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign {core_reset, core_wake, timeout_status_flag, power_down_status_flag, irq} =
        {q.core_reset, q.core_wake, q.timeout_flag, q.power_down_flag, q.irq};
    assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} =
        {q.awready, q.wready, q.bvalid, q.bresp};
    assign {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata} =
        {q.arready, q.rvalid, q.rresp, q.rdata};

endmodule : pur_seq

// ==== tb/pur_seq_chk.sv ====
/*
 * Timing checker for the power-up reset sequencer pins.
 * Assumes every watched pin is synchronous to ref_clk.
 */
`timescale 1ns/1ns
module pur_seq_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Causes
    input wire logic supply_good,
    input wire logic master_clear_pin_n,
    input wire logic watchdog_timeout,
    input wire logic core_sleep_cmd,
    input wire logic core_clear_watchdog,
    // Effects
    input wire logic core_reset,
    input wire logic core_wake,
    input wire logic timeout_status_flag,
    input wire logic power_down_status_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_por_holds_reset: assert property ($rose(supply_good) |=> core_reset)
        else $error("core reset low after supply rise");
    a_fall_no_reset: assert property ($fell(supply_good) && !core_reset && master_clear_pin_n
        && !watchdog_timeout |=> !core_reset) else $error("reset on supply fall");
    a_delay_order: assert property ($rose(supply_good) ##1 core_reset [*2]
        |=> core_reset) else $error("reset released between pulse and delay");
    a_por_flags: assert property ($rose(supply_good) |=>
        timeout_status_flag && power_down_status_flag) else $error("flags not set on power-on");
    a_pin_holds: assert property (!master_clear_pin_n |=> core_reset)
        else $error("core reset low with pin low");
    a_wdt_clears: assert property (watchdog_timeout && !core_reset && supply_good
        && $past(supply_good) && !core_clear_watchdog |=> !timeout_status_flag)
        else $error("timeout flag kept on watchdog");
    a_wdt_run_reset: assert property (watchdog_timeout && !core_reset
        && power_down_status_flag && supply_good && $past(supply_good) |=> core_reset)
        else $error("no reset on watchdog in run");
    a_sleep_flags: assert property (core_sleep_cmd && !core_reset && !watchdog_timeout
        && !core_clear_watchdog && supply_good && $past(supply_good)
        |=> timeout_status_flag && !power_down_status_flag) else $error("sleep flags wrong");
    c_release: cover property ($fell(core_reset));
    c_wake: cover property (core_wake);
    c_wdt_run: cover property (watchdog_timeout && !core_reset);
endmodule : pur_seq_chk

bind pur_seq pur_seq_chk u_pur_seq_chk (.*);

// ==== tb/pur_core_model.sv ====
/*
 * Processor core held in reset, and the external reset pin with pull-up.
 * Assumes bench requests change just after ref_clk edges.
 */
`timescale 1ns/1ns
module pur_core_model (
    // Clock and block output
    input wire logic ref_clk,
    input wire logic core_reset,
    // Bench requests
    input wire logic sleep_req,
    input wire logic pin_low_req,
    // Core and pin side
    output logic core_sleep_cmd,
    output logic master_clear_pin_n
);
    // A core held in reset executes nothing, so it cannot ask for sleep
    always_ff @(posedge ref_clk) core_sleep_cmd <= sleep_req && !core_reset;
    // Pull-up keeps the pin high unless pulled down
    assign master_clear_pin_n = !pin_low_req;
endmodule : pur_core_model

// ==== tb/pur_seq_tb_top.sv ====
/*
 * Self-checking bench for the power-up reset sequencer.
 * Assumes short delay parameters and a free-running oscillator input.
 */
`timescale 1ns/1ns
`include "pur_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module pur_seq_tb_top;
    localparam logic [11:0] A_PWR = {`PUR_IDX_POWER_CONTROL, 2'h0};
    localparam logic [11:0] A_STS = {`PUR_IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] A_MSK = {`PUR_IDX_IRQ_MASK, 2'h0};
    localparam logic [11:0] A_FLG = {`PUR_IDX_FLAGS, 2'h0};
    localparam logic [11:0] A_CFG = {`PUR_IDX_CONFIG, 2'h0};
    logic ref_clk = '0, rst_n = '0, supply_good = '0, main_osc_input = '0;
    logic watchdog_timeout = '0, core_clear_watchdog = '0, sleep_req = '0, pin_low_req = '0;
    logic core_sleep_cmd, master_clear_pin_n, core_reset, core_wake, irq;
    logic timeout_status_flag, power_down_status_flag;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int bad_count = 0, compares = 0, cyc = 0, n;

    pur_seq #(.POWER_UP_DELAY_TIMER_CYCLES(20), .OST_CYCLES(8)) u_pur_seq (.*);
    pur_core_model u_pur_core_model (.*);

    initial forever #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) main_osc_input <= ~main_osc_input;

    task automatic give_verdict();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        `CHK(s_axi_bresp, `PUR_RESP_OKAY)
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [33:0] x);
        exp_q.push_back(x);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask : rd

    task automatic pulse_wdt();
        watchdog_timeout <= 1'h1;
        @(posedge ref_clk);
        watchdog_timeout <= 1'h0;
    endtask : pulse_wdt

    // Read data is compared against the oldest note; refused reads carry no data
    always @(posedge ref_clk) if (s_axi_rvalid && s_axi_rready) begin
        e = exp_q.pop_front();
        `CHK({s_axi_rresp, s_axi_rresp[1] ? 32'h0 : s_axi_rdata}, e)
    end

    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(32'h29432B45));
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'h1;
        rd(A_CFG, 34'h2);
        supply_good <= 1'h1;
        n = 0;
        while (core_reset && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(n inside {[34:46]}, 1'h1)
        rd(A_PWR, 34'h0);
        rd(A_FLG, 34'h3);
        `CHK({timeout_status_flag, power_down_status_flag}, 2'h3)
        wr(A_PWR, 32'hFFFFFFFF);
        rd(A_PWR, 34'h2);
        pulse_wdt();
        rd(A_FLG, 34'h2);
        rd(A_PWR, 34'h2);
        `CHK(irq, 1'h0)
        wr(A_MSK, {28'($urandom()), 4'h2});
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'h1)
        wr(A_STS, 32'h2);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'h0)
        rd(A_STS, 34'h1);
        sleep_req <= 1'h1;
        @(posedge ref_clk);
        sleep_req <= 1'h0;
        rd(A_FLG, 34'h1);
        `CHK({timeout_status_flag, power_down_status_flag}, 2'h2)
        pulse_wdt();
        n = 0;
        while (!core_wake && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(n inside {[14:24]}, 1'h1)
        `CHK(core_reset, 1'h0)
        rd(A_FLG, 34'h0);
        wr(A_CFG, 32'h7);
        supply_good <= 1'h0;
        repeat (3) @(posedge ref_clk);
        `CHK(core_reset, 1'h0)
        pin_low_req <= 1'h1;
        supply_good <= 1'h1;
        repeat ($urandom_range(40, 4)) @(posedge ref_clk);
        `CHK(core_reset, 1'h1)
        pin_low_req <= 1'h0;
        repeat (3) @(posedge ref_clk);
        `CHK(core_reset, 1'h0)
        rd(A_PWR, 34'h0);
        rd(12'h100, {2'h2, 32'h0});
        give_verdict();
    end
endmodule : pur_seq_tb_top
